/* glk_map.svh */
`ifndef GLK_MAP_SVH
`define GLK_MAP_SVH

// clock and timebase
`define GLK_SYS_CLK_HZ 10000000
`define GLK_TICK_MS 1
`define GLK_TICK_CYC ((`GLK_SYS_CLK_HZ / 1000) * `GLK_TICK_MS)

// release delay selection, three ranges
`define GLK_REL_FINE_MS 100
`define GLK_REL_FINE_LAST 10
`define GLK_REL_MID_BASE_MS 1500
`define GLK_REL_MID_MS 500
`define GLK_REL_MID_LAST 28
`define GLK_REL_COARSE_BASE_MS 15000
`define GLK_REL_COARSE_MS 5000

// feedback window selection, three ranges
`define GLK_FBW_FINE_MS 10
`define GLK_FBW_FINE_LAST 9
`define GLK_FBW_MID_BASE_MS 150
`define GLK_FBW_MID_MS 50
`define GLK_FBW_MID_LAST 27
`define GLK_FBW_COARSE_BASE_MS 1500
`define GLK_FBW_COARSE_MS 500

// reset values
`define GLK_RST_MS 15'h0000
`define GLK_RST_DIV 14'h0000
`define GLK_RST_BIT 1'h0

`endif

/* glk_pkg.sv */
package glk_pkg;

   typedef logic [14:0] glk_ms_t;
   typedef logic [4:0]  glk_sel_t;
   typedef logic [13:0] glk_div_t;

   typedef enum logic [1:0] {
      ST_LOCKED   = 2'h0,
      ST_DELAY    = 2'h1,
      ST_UNLOCKED = 2'h2
   } glk_state_e;

   typedef struct packed {
      glk_state_e st;
      glk_ms_t    dly_cnt;
      glk_ms_t    fbw_cnt;
      logic       fb_wait;
      logic       fault;
      logic       unl;
      logic       energise;
      logic       main_out;
      logic       fault_flag;
   } glk_state_s;

   typedef struct packed {
      glk_div_t cnt;
      logic     tick;
   } glk_tick_s;

endpackage

/* glk_tick_if.sv */
`timescale 1ns/100ps
`default_nettype none

// millisecond timebase shared by both delay timers
interface glk_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface

`default_nettype wire

/* glk_tick.sv */
`timescale 1ns/100ps
`default_nettype none
`include "glk_map.svh"

// free-running divider, one-cycle tick per millisecond
module glk_tick
   import glk_pkg::*;
#(
   parameter glk_div_t TICK_CYC = glk_div_t'(`GLK_TICK_CYC)
)(
   input  wire logic sys_clk,
   input  wire logic rst_b,
   glk_tick_if.src   tb
);

   glk_tick_s r_reg;
   glk_tick_s r_next;

   // wrap at the period; never restarted, so both timers share phase
   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'h0;
      if (r_reg.cnt >= glk_div_t'(TICK_CYC - glk_div_t'(1))) begin
         r_next.cnt  = `GLK_RST_DIV;
         r_next.tick = 1'h1;
      end else begin
         r_next.cnt = r_reg.cnt + glk_div_t'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         r_reg <= '{cnt: `GLK_RST_DIV, tick: `GLK_RST_BIT};
      end else begin
         r_reg <= r_next;
      end
   end

   assign tb.tick = r_reg.tick;

endmodule

`default_nettype wire

/* glk_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "glk_map.svh"

// Behaviour
// - cross-check request, door and feedback; all outputs follow that check
// - request high means unlock, request low means lock again
// - no-door mode: main output high only if feedback locked and no fault
// - with-door mode: main output high only if door closed and locked
// - unlock request drops main output at once, then releases drive
// - any fault holds main output low
// - release delay elapses before drive switches to unlocking
// - drive is one two-valued energise signal
// - feedback must follow drive within window, else fault
// - feedback following within window raises no fault
// - enabled fault flag is high on fault, low otherwise
// - with-door mode: door open while commanded locked is a fault
// - gate-absent option selects no-door mode, door input ignored
// - door input high means door closed
// - no-door mode: request low relocks with no delay
// - main output returns high once relock confirmed and no fault
// - spring lock: de-energised is locked, energised is unlocked
// - release delay 0-1 s/100 ms, 1.5-10 s/0.5 s, 15-25 s/5 s
// - window 10-100 ms/10 ms, 150 ms-1 s/50 ms, 1.5-3 s/0.5 s
module glk_supervisor
   import glk_pkg::*;
#(
   parameter glk_div_t TICK_CYC = glk_div_t'(`GLK_TICK_CYC)
)(
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic unlock_req,
   input  wire logic lock_fbk,
   input  wire logic door_closed,
   input  wire logic gate_absent,
   input  wire logic spring_lock,
   input  wire logic fault_out_en,
   input  wire glk_sel_t unlock_sel,
   input  wire glk_sel_t fbk_sel,
   output var  logic lock_energise,
   output var  logic main_out,
   output var  logic fault_flag
);

   logic       rst_meta_b;
   logic       rst_sync_b;
   glk_state_s r_reg;
   glk_state_s r_next;
   glk_ms_t    rel_target;
   glk_ms_t    fbw_target;
   logic       locked_fb;
   logic       fb_match;
   logic       door_ok;
   logic       tick;

   glk_tick_if tick_bus ();

   // reset release through two flops; assertion is immediate
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'h0;
         rst_sync_b <= 1'h0;
      end else begin
         rst_meta_b <= 1'h1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // shared timebase
   // one divider for both timers keeps the tick phase common
   glk_tick #(
      .TICK_CYC (TICK_CYC)
   ) u_tick (
      .sys_clk (sys_clk),
      .rst_b   (rst_sync_b),
      .tb      (tick_bus.src)
   );

   assign tick = tick_bus.tick;

   // release delay decode
   // index 0..10 fine, 11..28 mid, 29..31 coarse
   function automatic glk_ms_t rel_ms(input glk_sel_t s);
      int i;
      int v;
      i = int'(s);
      if (i <= `GLK_REL_FINE_LAST) begin
         v = i * `GLK_REL_FINE_MS;
      end else if (i <= `GLK_REL_MID_LAST) begin
         v = `GLK_REL_MID_BASE_MS
             + (i - `GLK_REL_FINE_LAST - 1) * `GLK_REL_MID_MS;
      end else begin
         v = `GLK_REL_COARSE_BASE_MS
             + (i - `GLK_REL_MID_LAST - 1) * `GLK_REL_COARSE_MS;
      end
      return glk_ms_t'(v);
   endfunction

   // feedback window decode
   // index 0..9 fine, 10..27 mid, 28..31 coarse
   function automatic glk_ms_t fbw_ms(input glk_sel_t s);
      int i;
      int v;
      i = int'(s);
      if (i <= `GLK_FBW_FINE_LAST) begin
         v = (i + 1) * `GLK_FBW_FINE_MS;
      end else if (i <= `GLK_FBW_MID_LAST) begin
         v = `GLK_FBW_MID_BASE_MS
             + (i - `GLK_FBW_FINE_LAST - 1) * `GLK_FBW_MID_MS;
      end else begin
         v = `GLK_FBW_COARSE_BASE_MS
             + (i - `GLK_FBW_MID_LAST - 1) * `GLK_FBW_COARSE_MS;
      end
      return glk_ms_t'(v);
   endfunction

   assign rel_target = rel_ms(unlock_sel);
   assign fbw_target = fbw_ms(fbk_sel);

   // feedback polarity
   // contact closed means magnet energised; spring type locks unpowered
   assign locked_fb = spring_lock ? ~lock_fbk : lock_fbk;

   // door input high is door closed
   assign door_ok = gate_absent | door_closed;

   // feedback agrees with what the drive currently commands
   assign fb_match = (locked_fb == ~r_reg.unl);

   // next-state logic for the whole supervisor
   always_comb begin
      r_next = r_reg;

      // window check
      // the window may overrun by up to one tick, never shorten
      if (r_reg.fb_wait) begin
         if (fb_match) begin
            r_next.fb_wait = 1'h0;
         end else if (r_reg.fbw_cnt > fbw_target) begin
            r_next.fault   = 1'h1;
            r_next.fb_wait = 1'h0;
         end else if (tick) begin
            r_next.fbw_cnt = r_reg.fbw_cnt + glk_ms_t'(1);
         end
      end else if (!fb_match) begin
         // late or spontaneous change outside a window
         r_next.fault = 1'h1;
      end

      if (!gate_absent && !r_reg.unl && !door_closed) begin
         r_next.fault = 1'h1;
      end

      case (r_reg.st)
         ST_LOCKED: begin
            if (unlock_req) begin
               r_next.st      = ST_DELAY;
               r_next.dly_cnt = `GLK_RST_MS;
            end
         end
         ST_DELAY: begin
            if (!unlock_req) begin
               // withdrawn before release, drive never moved
               r_next.st = ST_LOCKED;
            end else if (r_reg.dly_cnt >= rel_target) begin
               r_next.st      = ST_UNLOCKED;
               r_next.unl     = 1'h1;
               r_next.fb_wait = 1'h1;
               r_next.fbw_cnt = `GLK_RST_MS;
            end else if (tick) begin
               r_next.dly_cnt = r_reg.dly_cnt + glk_ms_t'(1);
            end
         end
         ST_UNLOCKED: begin
            // with a door, relock waits for it to be closed
            if (!unlock_req && door_ok) begin
               r_next.st      = ST_LOCKED;
               r_next.unl     = 1'h0;
               r_next.fb_wait = 1'h1;
               r_next.fbw_cnt = `GLK_RST_MS;
            end
         end
         default: begin
            r_next.st  = ST_LOCKED;
            r_next.unl = 1'h0;
         end
      endcase

      r_next.energise = spring_lock ? r_next.unl : ~r_next.unl;

      r_next.main_out = (r_next.st == ST_LOCKED) && !r_next.unl
                        && !r_next.fb_wait && !r_next.fault
                        && locked_fb && door_ok && !unlock_req;

      r_next.fault_flag = fault_out_en & r_next.fault;
   end

   // reset state
   // energise resets low; a non-spring lock sees the locking level
   // one cycle after release
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         r_reg <= '{st: ST_LOCKED, dly_cnt: `GLK_RST_MS,
                    fbw_cnt: `GLK_RST_MS, fb_wait: `GLK_RST_BIT,
                    fault: `GLK_RST_BIT, unl: `GLK_RST_BIT,
                    energise: `GLK_RST_BIT, main_out: `GLK_RST_BIT,
                    fault_flag: `GLK_RST_BIT};
      end else begin
         r_reg <= r_next;
      end
   end

   assign lock_energise = r_reg.energise;
   assign main_out      = r_reg.main_out;
   assign fault_flag    = r_reg.fault_flag;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_sync_b);

   // request drops main output on the next edge
   req_drops_out_a: assert property (
      unlock_req |=> !r_reg.main_out)
      else $error("main output high after unlock request");

   // fault keeps main output low
   fault_blocks_out_a: assert property (
      r_reg.fault |-> !r_reg.main_out)
      else $error("main output high during fault");

   // main output needs locked feedback and a closed or absent door
   out_needs_lock_a: assert property (
      r_reg.main_out |-> $past(locked_fb) && $past(door_ok))
      else $error("main output high without confirmed lock");

   // enabled flag mirrors a held fault
   flag_follows_a: assert property (
      (r_reg.fault && fault_out_en) |=> r_reg.fault_flag)
      else $error("fault flag low during enabled fault");

   // flag never high without a fault
   flag_no_fault_a: assert property (
      !r_reg.fault |-> !r_reg.fault_flag)
      else $error("fault flag high without fault");

   // release happens only out of the delay state
   release_after_dly_a: assert property (
      $rose(r_reg.unl) |-> $past(r_reg.st) == ST_DELAY
                           && $past(r_reg.dly_cnt) >= $past(rel_target))
      else $error("drive released before delay elapsed");

   // zero delay releases two edges after the request
   zero_delay_a: assert property (
      (r_reg.st == ST_LOCKED && unlock_req && unlock_sel == 5'h00)
      ##1 (unlock_req && unlock_sel == 5'h00) |=> r_reg.unl)
      else $error("zero delay release late");

   // no-door mode relocks on the next edge
   nodoor_relock_a: assert property (
      (r_reg.unl && !unlock_req && gate_absent) |=> !r_reg.unl)
      else $error("no-door relock delayed");

   // window overrun becomes a fault
   window_fault_a: assert property (
      (r_reg.fb_wait && !fb_match && r_reg.fbw_cnt > fbw_target)
      |=> r_reg.fault)
      else $error("window overrun not flagged");

   // open door while locked becomes a fault
   door_fault_a: assert property (
      (!gate_absent && !r_reg.unl && !door_closed) |=> r_reg.fault)
      else $error("open door not flagged");

   // energise polarity against the unlock command
   spring_pol_a: assert property (
      ($past(rst_sync_b) && $past(spring_lock))
      |-> (r_reg.energise == r_reg.unl))
      else $error("spring lock polarity wrong");

   // non-spring lock energises to hold locked
   plain_pol_a: assert property (
      ($past(rst_sync_b) && !$past(spring_lock))
      |-> (r_reg.energise != r_reg.unl))
      else $error("plain lock polarity wrong");

   // mid range ends at ten seconds
   rel_mid_a: assert property (
      (unlock_sel == 5'h1C) |-> (rel_target == 15'h2710))
      else $error("mid release delay decode wrong");

   // coarse range ends at twenty-five seconds
   rel_coarse_a: assert property (
      (unlock_sel == 5'h1F) |-> (rel_target == 15'h61A8))
      else $error("coarse release delay decode wrong");

   // mid window range ends at one second
   fbw_mid_a: assert property (
      (fbk_sel == 5'h1B) |-> (fbw_target == 15'h03E8))
      else $error("mid feedback window decode wrong");

   // coarse window range ends at three seconds
   fbw_coarse_a: assert property (
      (fbk_sel == 5'h1F) |-> (fbw_target == 15'h0BB8))
      else $error("coarse feedback window decode wrong");

   // feedback arriving inside the window adds no fault
   follow_no_fault_a: assert property (
      (r_reg.fb_wait && fb_match && !r_reg.fault
       && (gate_absent || r_reg.unl || door_closed)) |=> !r_reg.fault)
      else $error("fault raised on in-window feedback");

   // confirmed relock with no fault raises main output next edge
   relock_raises_a: assert property (
      (r_reg.st == ST_LOCKED && !r_reg.unl && !r_reg.fb_wait
       && !r_reg.fault && locked_fb && door_ok && !unlock_req)
      |=> r_reg.main_out)
      else $error("main output not restored after relock");

   // request high while locked starts the release delay
   req_to_delay_a: assert property (
      (r_reg.st == ST_LOCKED && unlock_req) |=> (r_reg.st == ST_DELAY))
      else $error("unlock request not taken");

   // outputs still quiet at the first edge after release
   reset_quiet_a: assert property (
      $rose(rst_sync_b) |-> (!r_reg.main_out && !r_reg.fault_flag))
      else $error("outputs active straight after reset");

   // open door with a gate keeps main output low
   door_low_out_a: assert property (
      (!gate_absent && !door_closed) |=> !r_reg.main_out)
      else $error("main output high with door open");

   // window count restarts on each release
   window_restart_a: assert property (
      $rose(r_reg.unl) |-> (r_reg.fbw_cnt == 15'h0000))
      else $error("window count not restarted");

endmodule

`default_nettype wire

/* glk_lock_model.sv */
`timescale 1ns/100ps
`default_nettype none

// coil with its contact: contact follows the drive lat+1 cycles after it changes
module glk_lock_model (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        spring_lock,
   input  wire logic        lock_energise,
   input  wire logic [11:0] lat,
   output var  logic        lock_fbk
);
   logic [11:0] cnt_reg;

   // start at the locked level, else the supervisor faults at release
   // locked coil level
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lock_fbk <= !spring_lock;
         cnt_reg  <= 12'h000;
      end else if (lock_energise == lock_fbk) begin
         cnt_reg <= 12'h000;
      end else if (cnt_reg >= lat) begin
         lock_fbk <= lock_energise;
         cnt_reg  <= 12'h000;
      end else begin
         cnt_reg <= cnt_reg + 12'h001;
      end
   end
endmodule

`default_nettype wire

/* glk_supervisor_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) chk(nm, 16'(e), 16'(g))

module glk_supervisor_tb
   import glk_pkg::*;
;
   // short tick keeps the long delays affordable in simulation
   localparam int TICKC = 4;

   typedef struct packed {
      logic        ga;
      logic        sp;
      glk_sel_t    us;
      glk_sel_t    fs;
      logic [11:0] lat;
      logic [15:0] ms;
   } glk_row_s;

   logic        sys_clk      = 1'h0;
   logic        rst_b        = 1'h0;
   logic        unlock_req   = 1'h0;
   logic        door_closed  = 1'h1;
   logic        gate_absent  = 1'h1;
   logic        spring_lock  = 1'h1;
   logic        fault_out_en = 1'h1;
   glk_sel_t    unlock_sel   = 5'h00;
   glk_sel_t    fbk_sel      = 5'h00;
   logic [11:0] lat          = 12'h014;
   logic        lock_fbk;
   logic        lock_energise;
   logic        main_out;
   logic        fault_flag;
   int          failures     = 0;
   int          checked      = 0;
   int          n;

   // mode, lock type, delay, window, coil latency, expected delay in ms
   // latency below window
   glk_row_s rows[5] = '{
      '{1'h1, 1'h1, 5'h00, 5'h00, 12'h014, 16'h0000},
      '{1'h1, 1'h0, 5'h00, 5'h00, 12'h014, 16'h0000},
      '{1'h1, 1'h1, 5'h01, 5'h00, 12'h014, 16'h0064},
      '{1'h0, 1'h1, 5'h00, 5'h01, 12'h03C, 16'h0000},
      '{1'h0, 1'h0, 5'h0B, 5'h02, 12'h064, 16'h05DC}};

   glk_supervisor #(.TICK_CYC(14'h0004)) glk_supervisor_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .unlock_req(unlock_req),
      .lock_fbk(lock_fbk), .door_closed(door_closed),
      .gate_absent(gate_absent), .spring_lock(spring_lock),
      .fault_out_en(fault_out_en), .unlock_sel(unlock_sel),
      .fbk_sel(fbk_sel), .lock_energise(lock_energise),
      .main_out(main_out), .fault_flag(fault_flag));

   glk_lock_model glk_lock_model_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .spring_lock(spring_lock),
      .lock_energise(lock_energise), .lat(lat), .lock_fbk(lock_fbk));

   always #50 sys_clk = ~sys_clk;

   task automatic chk(input string nm, input logic [15:0] e, g);
      checked++;
      if (e !== g) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   // reset with a fresh configuration; fault is sticky, so each case needs it
   task automatic do_reset(input logic ga, sp, input glk_sel_t us, fs,
                           input logic [11:0] lt);
      tick(1);
      rst_b        <= 1'h0;
      gate_absent  <= ga;
      spring_lock  <= sp;
      unlock_sel   <= us;
      fbk_sel      <= fs;
      lat          <= lt;
      unlock_req   <= 1'h0;
      door_closed  <= 1'h1;
      fault_out_en <= 1'h1;
      tick(8);
      @(negedge sys_clk);
      `CHK("rst_main", 1'h0, main_out);
      `CHK("rst_fault", 1'h0, fault_flag);
      tick(1);
      rst_b <= 1'h1;
      tick(8);
      @(negedge sys_clk);
      `CHK("lock_level", !sp, lock_energise);
   endtask

   // counts edges from the request until the drive moves
   task automatic measure(output int cnt);
      logic e0;
      e0  = lock_energise;
      cnt = 0;
      do begin
         @(negedge sys_clk);
         cnt++;
         if (cnt == 2 && unlock_req) `CHK("main_drop", 1'h0, main_out);
      end while (lock_energise === e0 && cnt < 9000);
   endtask

   task automatic summarize();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ordinary unlock and relock cycles, one per row
   initial begin
      for (int i = 0; i < 5; i++) begin
         int c;
         int lo;
         c  = int'(rows[i].ms) * TICKC;
         lo = (c > 4) ? c - 1 : 3;
         do_reset(rows[i].ga, rows[i].sp, rows[i].us, rows[i].fs, rows[i].lat);
         `CHK("main_locked", 1'h1, main_out);
         tick(1);
         unlock_req <= 1'h1;
         measure(n);
         `CHK("rel_delay", 1'h1, n >= lo && n <= c + 7);
         `CHK("drive_unl", rows[i].sp, lock_energise);
         tick(150);
         if (!rows[i].ga) door_closed <= 1'h0;
         tick(10);
         door_closed <= 1'h1;
         @(negedge sys_clk);
         `CHK("fbk_ok", 1'h0, fault_flag);
         `CHK("main_unl", 1'h0, main_out);
         tick(1);
         unlock_req <= 1'h0;
         measure(n);
         `CHK("relock_fast", 1'h1, n <= 3);
         tick(150);
         @(negedge sys_clk);
         `CHK("main_back", 1'h1, main_out);
         `CHK("no_fault", 1'h0, fault_flag);
      end
      // coil slower than the window: fault, then masked, then sticky
      do_reset(1'h1, 1'h1, 5'h00, 5'h00, 12'h03C);
      tick(1);
      unlock_req <= 1'h1;
      measure(n);
      tick(30);
      @(negedge sys_clk);
      `CHK("in_window", 1'h0, fault_flag);
      tick(20);
      @(negedge sys_clk);
      `CHK("late_fbk", 1'h1, fault_flag);
      `CHK("fault_main", 1'h0, main_out);
      tick(1);
      fault_out_en <= 1'h0;
      unlock_req   <= 1'h0;
      tick(200);
      @(negedge sys_clk);
      `CHK("flag_off", 1'h0, fault_flag);
      `CHK("sticky", 1'h0, main_out);
      // door ignored without a gate; top codes exercise coarse decode
      do_reset(1'h1, 1'h1, 5'h1F, 5'h1F, 12'h014);
      tick(1);
      door_closed <= 1'h0;
      tick(20);
      @(negedge sys_clk);
      `CHK("no_gate_main", 1'h1, main_out);
      `CHK("no_gate_flt", 1'h0, fault_flag);
      // door opened while locked with a gate; mid range end codes
      do_reset(1'h0, 1'h1, 5'h1C, 5'h1B, 12'h014);
      tick(1);
      door_closed <= 1'h0;
      tick(5);
      @(negedge sys_clk);
      `CHK("door_main", 1'h0, main_out);
      `CHK("door_fault", 1'h1, fault_flag);
      // request dropped inside the release delay
      do_reset(1'h1, 1'h1, 5'h01, 5'h00, 12'h014);
      tick(1);
      unlock_req <= 1'h1;
      tick(3);
      @(negedge sys_clk);
      `CHK("abort_main", 1'h0, main_out);
      `CHK("abort_drv", 1'h0, lock_energise);
      tick(1);
      unlock_req <= 1'h0;
      tick(420);
      @(negedge sys_clk);
      `CHK("abort_hold", 1'h0, lock_energise);
      `CHK("abort_main2", 1'h1, main_out);
      `CHK("abort_flt", 1'h0, fault_flag);
      summarize();
   end

   // the sequence needs about 9000 cycles
   initial begin
      tick(45000);
      failures++;
      summarize();
   end
endmodule

`default_nettype wire
